// ### verilog/csd_defines.svh
// offsets, field positions, reset values and constants of the channel status decoder
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH
`define CSD_ADDR_W 4
`define CSD_DATA_W 32
`define CSD_OFS_CTRL 4'h0
`define CSD_OFS_STATUS 4'h1
`define CSD_OFS_MASK 4'h2
`define CSD_OFS_RAW 4'h3
`define CSD_OFS_COUNT 4'h4
`define CSD_CTRL_RESET 1'h1
`define CSD_MASK_RESET 3'h0
`define CSD_CTRL_CRC_EN 0
`define CSD_EV_DONE 0
`define CSD_EV_CRC 1
`define CSD_EV_SEQ 2
`define CSD_EV_W 3
`define CSD_LAST_BYTE 5'h17
`define CSD_CRC_POLY 8'h1D
`define CSD_CRC_INIT 8'hFF
`define CSD_MAX24_AUX 3'h1
`endif

// ### verilog/csd_pkg.sv
// types of the channel status decoder
package csd_pkg;
  typedef enum logic [2:0] {
    CSD_EMPH_NOT_IND = 3'h0, CSD_EMPH_NONE = 3'h1, CSD_EMPH_50_15 = 3'h2,
    CSD_EMPH_TEL = 3'h3, CSD_EMPH_RSVD = 3'h7
  } csd_emph_t;
  typedef enum logic [1:0] {
    CSD_FS_NOT_IND = 2'h0, CSD_FS_48K = 2'h1, CSD_FS_44K1 = 2'h2, CSD_FS_32K = 2'h3
  } csd_fs_t;
  typedef enum logic [3:0] {
    CSD_CH_NOT_IND = 4'h0, CSD_CH_TWO = 4'h1, CSD_CH_SINGLE = 4'h2, CSD_CH_PRI_SEC = 4'h3,
    CSD_CH_STEREO = 4'h4, CSD_CH_USER = 4'h5, CSD_CH_DBL = 4'h6, CSD_CH_DBL_LEFT = 4'h7,
    CSD_CH_DBL_RIGHT = 4'h8, CSD_CH_MULTI = 4'h9, CSD_CH_RSVD = 4'hF
  } csd_chmode_t;
  typedef enum logic [2:0] {
    CSD_UB_NONE = 3'h0, CSD_UB_BLK192 = 3'h1, CSD_UB_MSG = 3'h2, CSD_UB_USER = 3'h3,
    CSD_UB_CONSUMER = 3'h4, CSD_UB_RSVD = 3'h7
  } csd_ubits_t;
  typedef enum logic [2:0] {
    CSD_AUX_20_UNDEF = 3'h0, CSD_AUX_24_AUDIO = 3'h1, CSD_AUX_20_TALK = 3'h2,
    CSD_AUX_USER = 3'h3, CSD_AUX_RSVD = 3'h7
  } csd_aux_t;
  typedef enum logic [1:0] {
    CSD_AL_NOT_IND = 2'h0, CSD_AL_20DB = 2'h1, CSD_AL_18DB = 2'h2, CSD_AL_RSVD = 2'h3
  } csd_align_t;
  typedef enum logic [1:0] {
    CSD_ST_IDLE = 2'b00, CSD_ST_BYTES = 2'b01, CSD_ST_DROP = 2'b11
  } csd_state_t;
endpackage

// ### verilog/csd_decoder.sv
// channel status decoder: bytes 0 to 2 of the professional block, crc check, register port
// Overview of operation
// - byte 0 bit 0 gives consumer or professional use, bit 1 non-audio payload
// - byte 0 bits 2-4, bit 2 first, decode emphasis none, 50/15 or telephony
// - byte 0 bit 5 set reports source sampling frequency unlocked
// - byte 0 bits 6-7, bit 6 first: 48, 44.1 or 32 kHz base rate
// - byte 1 bits 0-3 decode two, single, primary/secondary, stereo or multichannel mode
// - channel codes 0111, 1000, 1001 are double-rate single channel; 0101, 0110 user defined
// - every unassigned code of any field is reported as reserved, never as a setting
// - byte 1 bits 4-7 decode user-bit management codes 0000 to 0100
// - byte 2 aux code 000 means 20-bit max, 001 means 24-bit max with audio
// - aux code 010 is 20-bit max with extra audio channel, 011 user defined
// - byte 2 bits 3-5 give word length below the 24 or 20 bit maximum
// - byte 2 bits 6-7 decode alignment level 20 dB, 18.06 dB or reserved
// - last byte crc must match before decoded fields are trusted
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`include "csd_defines.svh"
module csd_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] cs_byte,
  input wire logic cs_byte_valid,
  input wire logic cs_block_start,
  input wire logic [`CSD_ADDR_W-1:0] reg_addr,
  input wire logic [`CSD_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`CSD_DATA_W-1:0] reg_rdata,
  output logic irq,
  output logic pro_use,
  output logic non_audio,
  output csd_pkg::csd_emph_t emphasis,
  output logic fs_unlocked,
  output csd_pkg::csd_fs_t base_fs,
  output csd_pkg::csd_chmode_t channel_mode,
  output csd_pkg::csd_ubits_t user_bits,
  output csd_pkg::csd_aux_t aux_use,
  output logic [4:0] word_length,
  output logic word_length_rsvd,
  output csd_pkg::csd_align_t align_level
);
  import csd_pkg::*;
  csd_state_t state_reg;
  logic [4:0] idx_reg;
  logic [7:0] crc_reg;
  logic [7:0] crc_next;
  logic [7:0] b0_reg, b1_reg, b2_reg;
  logic crc_en_reg;
  logic [`CSD_EV_W-1:0] status_reg, mask_reg, ev_set;
  logic [15:0] count_reg;
  logic [`CSD_DATA_W-1:0] rdata_reg;
  logic irq_reg;
  logic last_byte, crc_bad, commit;
  logic [2:0] emph_code, aux_code, wl_code;
  logic [3:0] ch_code, ub_code;
  logic [1:0] fs_code, al_code;
  logic pro_reg, nonaud_reg, unlock_reg, wl_rsvd_reg;
  csd_emph_t emph_reg, emph_next;
  csd_fs_t fs_reg, fs_next;
  csd_chmode_t ch_reg, ch_next;
  csd_ubits_t ub_reg, ub_next;
  csd_aux_t aux_reg, aux_next;
  csd_align_t al_reg, al_next;
  logic [4:0] wl_reg, wl_next;
  logic wl_rsvd_next;
  // crc over one byte, lsb first as the bits arrive on the link
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[7] ^ d[i];
      r = {r[6:0], 1'b0} ^ (fb ? `CSD_CRC_POLY : 8'h00);
    end
    return r;
  endfunction
  // fields listed lowest bit first, so bit order is reversed into the codes
  assign emph_code = {b0_reg[2], b0_reg[3], b0_reg[4]};
  assign fs_code = {b0_reg[6], b0_reg[7]};
  assign ch_code = {b1_reg[0], b1_reg[1], b1_reg[2], b1_reg[3]};
  assign ub_code = {b1_reg[4], b1_reg[5], b1_reg[6], b1_reg[7]};
  assign aux_code = {b2_reg[0], b2_reg[1], b2_reg[2]};
  assign wl_code = {b2_reg[3], b2_reg[4], b2_reg[5]};
  assign al_code = {b2_reg[6], b2_reg[7]};
  assign crc_next = crc_step(crc_reg, cs_byte);
  assign last_byte = cs_byte_valid && !cs_block_start && state_reg == CSD_ST_BYTES && idx_reg == `CSD_LAST_BYTE;
  assign crc_bad = last_byte && crc_en_reg && crc_reg != cs_byte;
  assign commit = last_byte && !crc_bad;
  // byte sequencing; index and crc hold after the last byte, unused until a new start
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= CSD_ST_IDLE;
      idx_reg <= 5'h00;
      crc_reg <= `CSD_CRC_INIT;
    end else if (cs_byte_valid && cs_block_start) begin
      state_reg <= CSD_ST_BYTES;
      idx_reg <= 5'h01;
      crc_reg <= crc_step(`CSD_CRC_INIT, cs_byte);
    end else if (cs_byte_valid) begin
      case (state_reg)
        CSD_ST_BYTES: begin
          state_reg <= (idx_reg == `CSD_LAST_BYTE) ? CSD_ST_DROP : CSD_ST_BYTES;
          idx_reg <= idx_reg + 5'h01;
          crc_reg <= crc_next;
        end
        default: state_reg <= state_reg;
      endcase
    end
  end
  // shadow of bytes 0 to 2 of the block in progress
  always_ff @(posedge clk) begin
    if (rst) begin
      b0_reg <= 8'h00;
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
    end else if (cs_byte_valid) begin
      if (cs_block_start) begin
        b0_reg <= cs_byte;
      end else if (state_reg == CSD_ST_BYTES && idx_reg == 5'h01) begin
        b1_reg <= cs_byte;
      end else if (state_reg == CSD_ST_BYTES && idx_reg == 5'h02) begin
        b2_reg <= cs_byte;
      end
    end
  end

  // field decoders
  always_comb begin
    case (emph_code)
      3'h0: emph_next = CSD_EMPH_NOT_IND;
      3'h4: emph_next = CSD_EMPH_NONE;
      3'h6: emph_next = CSD_EMPH_50_15;
      3'h7: emph_next = CSD_EMPH_TEL;
      default: emph_next = CSD_EMPH_RSVD;
    endcase
    case (fs_code)
      2'h1: fs_next = CSD_FS_48K;
      2'h2: fs_next = CSD_FS_44K1;
      2'h3: fs_next = CSD_FS_32K;
      default: fs_next = CSD_FS_NOT_IND;
    endcase
    case (ch_code)
      4'h0: ch_next = CSD_CH_NOT_IND;
      4'h1: ch_next = CSD_CH_TWO;
      4'h2: ch_next = CSD_CH_SINGLE;
      4'h3: ch_next = CSD_CH_PRI_SEC;
      4'h4: ch_next = CSD_CH_STEREO;
      4'h5, 4'h6: ch_next = CSD_CH_USER;
      4'h7: ch_next = CSD_CH_DBL;
      4'h8: ch_next = CSD_CH_DBL_LEFT;
      4'h9: ch_next = CSD_CH_DBL_RIGHT;
      4'hF: ch_next = CSD_CH_MULTI;
      default: ch_next = CSD_CH_RSVD;
    endcase
    case (ub_code)
      4'h0: ub_next = CSD_UB_NONE;
      4'h1: ub_next = CSD_UB_BLK192;
      4'h2: ub_next = CSD_UB_MSG;
      4'h3: ub_next = CSD_UB_USER;
      4'h4: ub_next = CSD_UB_CONSUMER;
      default: ub_next = CSD_UB_RSVD;
    endcase
    case (aux_code)
      3'h0: aux_next = CSD_AUX_20_UNDEF;
      3'h1: aux_next = CSD_AUX_24_AUDIO;
      3'h2: aux_next = CSD_AUX_20_TALK;
      3'h3: aux_next = CSD_AUX_USER;
      default: aux_next = CSD_AUX_RSVD;
    endcase
    case (al_code)
      2'h1: al_next = CSD_AL_20DB;
      2'h2: al_next = CSD_AL_18DB;
      2'h3: al_next = CSD_AL_RSVD;
      default: al_next = CSD_AL_NOT_IND;
    endcase
    // length below a 24-bit maximum, less four below a 20-bit one
    wl_rsvd_next = 1'b0;
    case (wl_code)
      3'h0: wl_next = 5'd0;
      3'h1: wl_next = 5'd23;
      3'h2: wl_next = 5'd22;
      3'h3: wl_next = 5'd21;
      3'h4: wl_next = 5'd20;
      3'h5: wl_next = 5'd24;
      default: begin
        wl_next = 5'd0;
        wl_rsvd_next = 1'b1;
      end
    endcase
    if (aux_code != `CSD_MAX24_AUX && wl_next != 5'd0) begin
      wl_next = wl_next - 5'd4;
    end
  end
  // decoded fields, all taken together on a good block
  always_ff @(posedge clk) begin
    if (rst) begin
      pro_reg <= 1'b0;
      nonaud_reg <= 1'b0;
      unlock_reg <= 1'b0;
      emph_reg <= CSD_EMPH_NOT_IND;
      fs_reg <= CSD_FS_NOT_IND;
      ch_reg <= CSD_CH_NOT_IND;
      ub_reg <= CSD_UB_NONE;
      aux_reg <= CSD_AUX_20_UNDEF;
      wl_reg <= 5'd0;
      wl_rsvd_reg <= 1'b0;
      al_reg <= CSD_AL_NOT_IND;
    end else if (commit) begin
      pro_reg <= b0_reg[0];
      nonaud_reg <= b0_reg[1];
      unlock_reg <= b0_reg[5];
      emph_reg <= emph_next;
      fs_reg <= fs_next;
      ch_reg <= ch_next;
      ub_reg <= ub_next;
      aux_reg <= aux_next;
      wl_reg <= wl_next;
      wl_rsvd_reg <= wl_rsvd_next;
      al_reg <= al_next;
    end
  end
  // events: done, crc mismatch, byte after block end without a new start
  assign ev_set[`CSD_EV_DONE] = commit;
  assign ev_set[`CSD_EV_CRC] = crc_bad;
  assign ev_set[`CSD_EV_SEQ] = cs_byte_valid && !cs_block_start && state_reg == CSD_ST_DROP;

  // control, mask and sticky status; a new event beats the read clear
  always_ff @(posedge clk) begin
    if (rst) begin
      crc_en_reg <= `CSD_CTRL_RESET;
      mask_reg <= `CSD_MASK_RESET;
      status_reg <= '0;
      count_reg <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `CSD_OFS_CTRL) begin
        crc_en_reg <= reg_wdata[`CSD_CTRL_CRC_EN];
      end
      if (reg_wr && reg_addr == `CSD_OFS_MASK) begin
        mask_reg <= reg_wdata[`CSD_EV_W-1:0];
      end
      if (reg_rd && reg_addr == `CSD_OFS_STATUS) begin
        status_reg <= ev_set;
      end else begin
        status_reg <= status_reg | ev_set;
      end
      if (commit) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst || !reg_rd) begin
      rdata_reg <= '0;
    end else begin
      case (reg_addr)
        `CSD_OFS_CTRL: rdata_reg <= {31'h0, crc_en_reg};
        `CSD_OFS_STATUS: rdata_reg <= {29'h0, status_reg};
        `CSD_OFS_MASK: rdata_reg <= {29'h0, mask_reg};
        `CSD_OFS_RAW: rdata_reg <= {8'h00, b2_reg, b1_reg, b0_reg};
        `CSD_OFS_COUNT: rdata_reg <= {16'h0000, count_reg};
        default: rdata_reg <= '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;
  assign pro_use = pro_reg;
  assign non_audio = nonaud_reg;
  assign emphasis = emph_reg;
  assign fs_unlocked = unlock_reg;
  assign base_fs = fs_reg;
  assign channel_mode = ch_reg;
  assign user_bits = ub_reg;
  assign aux_use = aux_reg;
  assign word_length = wl_reg;
  assign word_length_rsvd = wl_rsvd_reg;
  assign align_level = al_reg;

  AST_PRO_FLAGS: assert property (@(posedge clk) disable iff (rst)
    commit |=> pro_use == $past(b0_reg[0]) && non_audio == $past(b0_reg[1]))
    else $error("use or payload flag not taken from byte 0");
  AST_EMPH_5015: assert property (@(posedge clk) disable iff (rst)
    commit && emph_code == 3'h6 |=> emphasis == CSD_EMPH_50_15)
    else $error("emphasis 110 misdecoded");
  AST_UNLOCK: assert property (@(posedge clk) disable iff (rst)
    commit && b0_reg[5] |=> fs_unlocked)
    else $error("unlock flag lost");
  AST_FS48: assert property (@(posedge clk) disable iff (rst)
    commit && !b0_reg[6] && b0_reg[7] |=> base_fs == CSD_FS_48K)
    else $error("48 kHz misdecoded");
  AST_STEREO: assert property (@(posedge clk) disable iff (rst)
    commit && ch_code == 4'h4 |=> channel_mode == CSD_CH_STEREO)
    else $error("stereo misdecoded");
  AST_DBL_LEFT: assert property (@(posedge clk) disable iff (rst)
    commit && ch_code == 4'h8 |=> channel_mode == CSD_CH_DBL_LEFT)
    else $error("double rate left misdecoded");
  AST_CH_RSVD: assert property (@(posedge clk) disable iff (rst)
    commit && ch_code == 4'hA |=> channel_mode == CSD_CH_RSVD)
    else $error("unassigned channel code not reserved");
  AST_UB192: assert property (@(posedge clk) disable iff (rst)
    commit && ub_code == 4'h1 |=> user_bits == CSD_UB_BLK192)
    else $error("192-bit user structure misdecoded");
  AST_WL24: assert property (@(posedge clk) disable iff (rst)
    commit && aux_code == 3'h1 && wl_code == 3'h5 |=> aux_use == CSD_AUX_24_AUDIO && word_length == 5'd24)
    else $error("24-bit word misdecoded");
  AST_WL16: assert property (@(posedge clk) disable iff (rst)
    commit && aux_code == 3'h2 && wl_code == 3'h4 |=> aux_use == CSD_AUX_20_TALK && word_length == 5'd16)
    else $error("20-bit max length misdecoded");
  AST_ALIGN18: assert property (@(posedge clk) disable iff (rst)
    commit && al_code == 2'h2 |=> align_level == CSD_AL_18DB)
    else $error("18.06 dB alignment misdecoded");
  AST_CRC_HOLD: assert property (@(posedge clk) disable iff (rst)
    crc_bad |=> status_reg[`CSD_EV_CRC] && $stable(channel_mode) && $stable(emphasis) && $stable(word_length))
    else $error("bad crc block changed fields");
  AST_STABLE: assert property (@(posedge clk) disable iff (rst)
    !commit |=> $stable(base_fs) && $stable(user_bits) && $stable(align_level) && $stable(pro_use))
    else $error("fields moved without a good block");
  AST_RESET: assert property (@(posedge clk)
    rst |=> base_fs == CSD_FS_NOT_IND && channel_mode == CSD_CH_NOT_IND && word_length == 5'd0)
    else $error("reset did not clear fields");
  COV_GOOD: cover property (@(posedge clk) disable iff (rst) commit);
  COV_BAD: cover property (@(posedge clk) disable iff (rst) crc_bad);
  COV_SEQ: cover property (@(posedge clk) disable iff (rst) ev_set[`CSD_EV_SEQ]);
  COV_IRQ: cover property (@(posedge clk) disable iff (rst) $rose(irq));
endmodule

// ### test/csd_rx_model.sv
// receiver model handing assembled channel status bytes to the decoder
`timescale 1ns/1ns
module csd_rx_model (
  input wire logic clk,
  output logic [7:0] cs_byte,
  output logic cs_byte_valid,
  output logic cs_block_start
);
  initial begin
    cs_byte = 8'h00;
    cs_byte_valid = 1'b0;
    cs_block_start = 1'b0;
  end
  task automatic put(input logic [7:0] b, input logic st);
    @(posedge clk);
    cs_byte <= b;
    cs_byte_valid <= 1'b1;
    cs_block_start <= st;
  endtask
  // released lane toggles so a stale byte never looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      cs_byte_valid <= 1'b0;
      cs_block_start <= 1'b0;
      cs_byte <= ~cs_byte;
    end
  endtask
  // last byte is the crc over the others, inverted when bad is set
  task automatic send(input logic [23:0] hd, input logic bad, input int len, input int gap);
    logic [7:0] crc;
    logic [7:0] d;
    crc = 8'hFF;
    for (int k = 0; k < len; k++) begin
      d = (k < 3) ? hd[8*k+:8] : 8'(k * 8'h25);
      if (k == 23) d = bad ? ~crc : crc;
      for (int i = 0; i < 8; i++) crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ d[i]) ? 8'h1D : 8'h00);
      put(d, k == 0);
      if (gap > 0) idle(gap);
    end
    idle(1);
  endtask
endmodule

// ### test/testbench.sv
// self-checking bench of the channel status decoder
`timescale 1ns/1ns
`include "csd_defines.svh"
module testbench;
  import csd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq, pro_use, non_audio, fs_unlocked, word_length_rsvd;
  logic [7:0] cs_byte;
  logic cs_byte_valid, cs_block_start;
  csd_emph_t emphasis;
  csd_fs_t base_fs;
  csd_chmode_t channel_mode;
  csd_ubits_t user_bits;
  csd_aux_t aux_use;
  logic [4:0] word_length;
  csd_align_t align_level;
  int error_cnt = 0;
  int n_compared = 0;
  logic [23:0] exp_hd = 24'h0;
  logic [15:0] exp_cnt = 16'h0;
  logic [15:0] seed = 16'h5F28; // 24360
  logic [2:0] em_map [8] = '{3'h0, 3'h7, 3'h7, 3'h7, 3'h1, 3'h7, 3'h2, 3'h3};
  logic [3:0] ch_map [16] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h5, 4'h6, 4'h7, 4'h8,
    4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'h9};
  always #50 clk = ~clk;
  csd_rx_model rx_u (.clk, .cs_byte, .cs_byte_valid, .cs_block_start);
  csd_decoder dut_u (.clk, .rst, .cs_byte, .cs_byte_valid, .cs_block_start, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq, .pro_use, .non_audio, .emphasis, .fs_unlocked, .base_fs,
    .channel_mode, .user_bits, .aux_use, .word_length, .word_length_rsvd, .align_level);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // bit order flip: lowest bit of a field is the first printed digit
  function automatic logic [3:0] rv(input logic [3:0] c, input int n);
    logic [3:0] r = 4'h0;
    for (int i = 0; i < n; i++) r[i] = c[n - 1 - i];
    return r;
  endfunction
  task automatic print_verdict();
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chk_fields();
    logic [3:0] ch, ub, ax, wl;
    logic [4:0] wexp;
    ch = rv(4'(exp_hd >> 8), 4);
    ub = rv(4'(exp_hd >> 12), 4);
    ax = rv(4'(exp_hd >> 16), 3);
    wl = rv(4'(exp_hd >> 19), 3);
    wexp = (wl == 4'h5) ? 5'h18 : 5'(8'h18 - wl);
    if (ax != 4'h1) wexp -= 5'h4;
    if (wl == 4'h0 || wl > 4'h5) wexp = 5'h0;
    chk("pro_use", pro_use, exp_hd[0]);
    chk("non_audio", non_audio, exp_hd[1]);
    chk("emphasis", emphasis, em_map[rv(4'(exp_hd >> 2), 3)]);
    chk("fs_unlocked", fs_unlocked, exp_hd[5]);
    chk("base_fs", base_fs, rv(4'(exp_hd >> 6), 2));
    chk("channel_mode", channel_mode, ch_map[ch]);
    chk("user_bits", user_bits, ub > 4'h4 ? 4'h7 : ub);
    chk("aux_use", aux_use, ax > 4'h3 ? 4'h7 : ax);
    chk("word_length", word_length, wexp);
    chk("word_length_rsvd", word_length_rsvd, wl > 4'h5);
    chk("align_level", align_level, rv(4'(exp_hd >> 22), 2));
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(nm, reg_rdata, exp);
  endtask
  task automatic blk(input logic [23:0] hd, input logic bad, input logic crc_on, input int gap);
    logic good;
    good = !(bad && crc_on);
    rx_u.send(hd, bad, 24, gap);
    repeat (2) @(posedge clk);
    @(negedge clk);
    if (good) begin
      exp_hd = hd;
      exp_cnt++;
    end
    chk_fields();
    chk("irq", irq, 1'b1);
    rd("raw", `CSD_OFS_RAW, {8'h00, hd});
    rd("status", `CSD_OFS_STATUS, good ? 32'h1 : 32'h2);
    rd("count", `CSD_OFS_COUNT, {16'h0, exp_cnt});
    chk("irq", irq, 1'b0);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    logic [23:0] hd;
    logic [3:0] c;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_fields();
    chk("irq", irq, 1'b0);
    rd("ctrl", `CSD_OFS_CTRL, 32'h1);
    rd("mask", `CSD_OFS_MASK, 32'h0);
    rd("count", `CSD_OFS_COUNT, 32'h0);
    rd("unmapped", 4'h9, 32'h0);
    wr(`CSD_OFS_STATUS, 32'h7);
    rd("status", `CSD_OFS_STATUS, 32'h0);
    wr(`CSD_OFS_MASK, 32'h3);
    // every code of every field, bytes of each block back to back
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      hd = {2'(rv(c, 2)), 3'(rv(c, 3)), 3'(rv(c[3] ? 4'h1 : c & 4'h7, 3)), rv(c, 4), rv(c, 4),
        2'(rv(c, 2)), c[2], 3'(rv(c, 3)), c[1], c[0]};
      blk(hd, 1'b0, 1'b1, 0);
    end
    for (int i = 0; i < 30; i++) begin
      seed = lfsr(seed);
      hd[15:0] = seed;
      seed = lfsr(seed);
      hd[23:16] = seed[7:0];
      blk(hd, seed[15:13] == 3'h0, 1'b1, int'(seed[9:8]));
    end
    blk(24'h5A3C96, 1'b1, 1'b1, 0);
    wr(`CSD_OFS_CTRL, 32'h0);
    rd("ctrl", `CSD_OFS_CTRL, 32'h0);
    blk(24'hA5C3E1, 1'b1, 1'b0, 1);
    wr(`CSD_OFS_CTRL, 32'h1);
    // cut block then restart: outputs hold until a whole block lands
    rx_u.send(24'h123456, 1'b0, 10, 0);
    @(negedge clk);
    chk_fields();
    blk(24'h654321, 1'b0, 1'b1, 0);
    rx_u.put(8'h3C, 1'b0);
    rx_u.idle(2);
    @(negedge clk);
    chk_fields();
    chk("irq", irq, 1'b0);
    wr(`CSD_OFS_MASK, 32'h7);
    @(posedge clk);
    @(negedge clk);
    chk("irq", irq, 1'b1);
    rd("status", `CSD_OFS_STATUS, 32'h4);
    // reset in mid-run with decoded fields set
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    exp_hd = 24'h0;
    exp_cnt = 16'h0;
    chk_fields();
    chk("irq", irq, 1'b0);
    rd("mask", `CSD_OFS_MASK, 32'h0);
    rd("count", `CSD_OFS_COUNT, 32'h0);
    print_verdict();
  end
endmodule
